// ### verilog/fbs_pkg.sv
// shared constants and carrier types of the fieldbus slave host serial block
// assumes a single 10 MHz core clock; codes are the host serial frame codes
`default_nettype none

package fbs_pkg;

   // ***********************************************
   // timing
   // ***********************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int ATTN_TMO_MS = 100;
   localparam int ATTN_TMO_CYC = CLK_HZ / 1000 * ATTN_TMO_MS;
   localparam int HOST_BAUD = 115200;
   localparam int BIT_CYC = CLK_HZ / HOST_BAUD;

   // ***********************************************
   // frame codes and sizes
   // ***********************************************
   localparam logic [7:0] CMD_CFG_A = 8'h01;
   localparam logic [7:0] CMD_CFG_B = 8'h02;
   localparam logic [7:0] CMD_PDEF = 8'h20;
   localparam logic [7:0] RSP_PDEF = 8'ha0;
   localparam logic [7:0] CMD_PREQ = 8'h0e;
   localparam logic [7:0] RSP_PREQ = 8'h8e;
   localparam logic [7:0] CMD_IO = 8'h10;
   localparam logic [7:0] RSP_FLAG = 8'h80;
   localparam logic [7:0] ACC_RW = 8'h01;
   localparam logic [7:0] ACC_RO = 8'h00;
   localparam int IO_BYTES = 4;
   localparam int PRM_MAX = 8;
   localparam int TXQ_DEPTH = 4;

   // network side status as seen by the protocol stack
   typedef struct packed {
      logic auto_baud;
      logic can_traffic;
      logic chk_done;
      logic addr_conflict;
      logic baud_mismatch;
   } fbs_net_t;

   // status indications driven out
   typedef struct packed {
      logic listening;
      logic online;
      logic net_fault;
      logic bus_off;
   } fbs_stat_t;

   // answer to a remote parameter read
   typedef struct packed {
      logic done;
      logic err;
      logic [7:0] num;
      logic [15:0] data;
   } fbs_prm_rsp_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_TX = 3'b001,
      ST_ATTN = 3'b010,
      ST_PRSP = 3'b011
   } fbs_state_t;

endpackage : fbs_pkg

`default_nettype wire

// ### verilog/fbs_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth must be a power of two
`default_nettype none

module fbs_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);

   initial begin
      if (D < 2 || (1 << AW) != D || W < 1) $error("fbs_fifo: bad W or D");
   end

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } fbs_fifo_st_t;

   fbs_fifo_st_t s_reg, s_next;
   logic full, empty;

   // full when pointers differ only in the wrap bit
   assign full = (s_reg.wp[AW] != s_reg.rp[AW]) && (s_reg.wp[AW-1:0] == s_reg.rp[AW-1:0]);
   assign empty = (s_reg.wp == s_reg.rp);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = s_reg.mem[s_reg.rp[AW-1:0]];

   // push and pop
   always_comb begin
      s_next = s_reg;
      if (in_valid && !full) begin
         s_next.mem[s_reg.wp[AW-1:0]] = in_data;
         s_next.wp = s_reg.wp + 1'b1;
      end
      if (out_ready && !empty) begin
         s_next.rp = s_reg.rp + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : fbs_fifo

`default_nettype wire

// ### verilog/fbs_uart.sv
// host uart, 8 data bits, one stop bit, no parity
// assumes rxd synchronous to clk and idle high
`default_nettype none

module fbs_uart #(
   parameter int BIT_CYC = fbs_pkg::BIT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rxd,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   output logic txd
);
   initial begin
      if (BIT_CYC < 4 || BIT_CYC > 65535) $error("fbs_uart: bad BIT_CYC");
   end

   typedef struct packed {
      logic rx_busy;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_valid;
      logic [15:0] tx_div;
      logic tx_busy;
      logic [3:0] tx_bit;
      logic [9:0] tx_sh;
      logic txd;
   } fbs_uart_st_t;

   fbs_uart_st_t s_reg, s_next;
   logic tick;

   assign tick = (s_reg.tx_div == 16'h0000);
   assign rx_valid = s_reg.rx_valid;
   assign rx_data = s_reg.rx_sh;
   assign tx_ready = !s_reg.tx_busy;
   assign txd = s_reg.txd;

   // receiver samples mid bit; transmitter steps on a free divider enable
   always_comb begin
      s_next = s_reg;
      s_next.rx_valid = 1'b0;
      if (!s_reg.rx_busy) begin
         if (!rxd) begin
            s_next.rx_busy = 1'b1;
            s_next.rx_cnt = 16'(BIT_CYC / 2);
            s_next.rx_bit = 4'h0;
         end
      end else if (s_reg.rx_cnt != 16'h0000) begin
         s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
      end else begin
         s_next.rx_cnt = 16'(BIT_CYC - 1);
         s_next.rx_bit = s_reg.rx_bit + 4'h1;
         if (s_reg.rx_bit == 4'h0) begin
            s_next.rx_busy = !rxd; // false start drops back to idle
         end else if (s_reg.rx_bit == 4'h9) begin
            s_next.rx_busy = 1'b0;
            s_next.rx_valid = rxd; // framing error drops the byte
         end else begin
            s_next.rx_sh = {rxd, s_reg.rx_sh[7:1]};
         end
      end
      s_next.tx_div = tick ? 16'(BIT_CYC - 1) : s_reg.tx_div - 16'h0001;
      if (!s_reg.tx_busy && tx_valid) begin
         s_next.tx_busy = 1'b1;
         s_next.tx_bit = 4'h0;
         s_next.tx_sh = {1'b1, tx_data, 1'b0};
      end else if (s_reg.tx_busy && tick) begin
         if (s_reg.tx_bit == 4'ha) begin
            s_next.tx_busy = 1'b0;
         end else begin
            s_next.txd = s_reg.tx_sh[0];
            s_next.tx_sh = {1'b1, s_reg.tx_sh[9:1]};
            s_next.tx_bit = s_reg.tx_bit + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.txd <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : fbs_uart

`default_nettype wire

// ### verilog/fbs_core.sv
// host serial protocol engine of the fieldbus slave: config commands,
// attention/ready handshake for remote parameter reads, i/o data buffer
// assumes all inputs synchronous to core_clk; network stack is outside
// Functional notes
// R1: config state accepts only codes 01, 02, 20
// R2: parameter define 20 answered with a0 frame
// R3: access flag after type: 01 rw, 00 ro
// R4: remote read in serial mode pulls attention low
// R5: host pulls ready low when able to receive
// R6: on ready, send parameter request frame 0e
// R7: host answers parameter request with 8e frame
// R8: good 8e answer forwarded to remote master
// R9: no ready in 100 ms gives resource error
// R10: remote read discards partial host frames first
// R11: while awaiting ready, host requests get no answer
// R12: remote read between host requests same handling
// R13: master output buffered, returned on host i/o
// R14: host i/o data held, served to master
// R15: newest master output overwrites older output
// R16: host link 8n1 no parity, matching baud
// R17: auto baud with no traffic ignores host
// R18: address conflict keeps offline, flags network fault
// R19: wrong network baud enters bus off
// R20: attention released on ready or timeout
`default_nettype none

module fbs_core #(
   parameter int TMO_CYC = fbs_pkg::ATTN_TMO_CYC,
   parameter int BIT_CYC = fbs_pkg::BIT_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic host_rxd,
   output logic host_txd,
   output logic attn_n,
   input wire logic host_rdy_n,
   input wire logic cfg_state,
   input wire logic serial_mode,
   input wire fbs_pkg::fbs_net_t net,
   output fbs_pkg::fbs_stat_t stat,
   input wire logic prm_req,
   input wire logic [7:0] prm_req_num,
   output fbs_pkg::fbs_prm_rsp_t prm_rsp,
   input wire logic out_wr,
   input wire logic [fbs_pkg::IO_BYTES*8-1:0] out_wr_data,
   output logic [fbs_pkg::IO_BYTES*8-1:0] in_data,
   output logic [fbs_pkg::PRM_MAX-1:0] prm_rw_mask
);
   import fbs_pkg::*;

   localparam int TW = $clog2(TMO_CYC + 1);

   initial begin
      if (TMO_CYC < 1 || IO_BYTES < 3) $error("fbs_core: bad TMO_CYC or IO_BYTES");
   end

   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed {
      fbs_state_t st;
      logic [8:0] rcnt;
      logic [7:0] rcmd;
      logic [7:0] rlen;
      logic [7:0] rcks;
      logic [IO_BYTES-1:0][7:0] rpay;
      logic [PRM_MAX-1:0] rmask;
      logic [7:0] tcmd;
      logic [7:0] tlen;
      logic [IO_BYTES-1:0][7:0] tpay;
      logic [7:0] tidx;
      logic [7:0] tcks;
      logic preq;
      logic pend;
      logic [TW-1:0] tmr;
      logic attn_n;
      logic [IO_BYTES-1:0][7:0] out_buf;
      logic [IO_BYTES-1:0][7:0] in_buf;
      logic [PRM_MAX-1:0] mask;
      fbs_stat_t stat;
      fbs_prm_rsp_t rsp;
   } fbs_core_st_t;

   fbs_core_st_t s_reg, s_next;

   logic rx_v;
   logic [7:0] rx_b;
   logic q_valid, q_ready, u_valid, u_ready;
   logic [7:0] q_data, u_data;
   logic listen, good_end, rx_ok;
   logic [7:0] tbyte;

   // ***********************************************
   // host uart and transmit queue
   // ***********************************************
   fbs_uart #(
      .BIT_CYC(BIT_CYC)
   ) u_uart (
      .clk(core_clk),
      .rst_n(rst_n),
      .rxd(host_rxd),
      .rx_valid(rx_v),
      .rx_data(rx_b),
      .tx_valid(u_valid),
      .tx_ready(u_ready),
      .tx_data(u_data),
      .txd(host_txd)
   );

   // uart stalls the queue, a full queue stalls the frame sender
   fbs_fifo #(
      .W(8),
      .D(TXQ_DEPTH)
   ) u_txq (
      .clk(core_clk),
      .rst_n(rst_n),
      .in_valid(q_valid),
      .in_ready(q_ready),
      .in_data(q_data),
      .out_valid(u_valid),
      .out_ready(u_ready),
      .out_data(u_data)
   );

   // ***********************************************
   // outputs
   // ***********************************************
   assign attn_n = s_reg.attn_n;
   assign stat = s_reg.stat;
   assign prm_rsp = s_reg.rsp;
   assign in_data = s_reg.in_buf;
   assign prm_rw_mask = s_reg.mask;
   assign q_valid = (s_reg.st == ST_TX);
   assign q_data = tbyte;

   // byte of the outgoing frame: cmd, len, payload, checksum
   always_comb begin
      tbyte = s_reg.tcks;
      if (s_reg.tidx == 8'h00) begin
         tbyte = s_reg.tcmd;
      end else if (s_reg.tidx == 8'h01) begin
         tbyte = s_reg.tlen;
      end else begin
         for (int i = 0; i < IO_BYTES; i++) begin
            if (s_reg.tidx == 8'(i + 2) && 8'(i) < s_reg.tlen) tbyte = s_reg.tpay[i];
         end
      end
   end

   // host bytes are taken only when idle or awaiting the 8e answer
   assign listen = s_reg.stat.listening;
   assign rx_ok = rx_v && !listen && ((s_reg.st == ST_IDLE && !s_reg.pend) ||
                  s_reg.st == ST_PRSP); // see R17 see R11
   assign good_end = rx_ok && (s_reg.rcnt >= 9'h002) &&
                     (s_reg.rcnt == {1'b0, s_reg.rlen} + 9'h002) && (s_reg.rcks == rx_b);

   // ***********************************************
   // protocol engine
   // ***********************************************
   always_comb begin
      s_next = s_reg;
      s_next.rsp.done = 1'b0;
      s_next.rsp.err = 1'b0;

      // network status indications
      s_next.stat.listening = net.auto_baud && !net.can_traffic; // see R17
      s_next.stat.net_fault = net.addr_conflict || net.baud_mismatch; // see R18
      s_next.stat.bus_off = net.baud_mismatch; // see R19
      s_next.stat.online = net.chk_done && !net.addr_conflict &&
                           !net.baud_mismatch && !s_next.stat.listening; // see R18

      // frame parser: cmd, len, payload, additive checksum
      if (rx_ok) begin
         s_next.rcks = s_reg.rcks + rx_b;
         s_next.rcnt = s_reg.rcnt + 9'h001;
         if (s_reg.rcnt == 9'h000) begin
            s_next.rcmd = rx_b;
            s_next.rcks = rx_b;
         end else if (s_reg.rcnt == 9'h001) begin
            s_next.rlen = rx_b;
         end else if (s_reg.rcnt == {1'b0, s_reg.rlen} + 9'h002) begin
            s_next.rcnt = 9'h000;
         end
         for (int i = 0; i < IO_BYTES; i++) begin
            if (s_reg.rcnt == 9'(i + 2)) s_next.rpay[i] = rx_b;
         end
         for (int i = 0; i < PRM_MAX; i++) begin
            // flag byte follows each data type byte
            if (s_reg.rcnt == 9'(2 * i + 4) && s_reg.rcnt < {1'b0, s_reg.rlen} + 9'h002) begin
               s_next.rmask[i] = (rx_b == ACC_RW); // see R3
            end
         end
      end

      // completed host frames
      if (good_end) begin
         if (s_reg.st == ST_PRSP) begin
            if (s_reg.rcmd == RSP_PREQ && s_reg.rpay[0] == s_reg.rsp.num) begin // see R7
               s_next.rsp.done = 1'b1; // see R8
               s_next.rsp.data = {s_reg.rpay[2], s_reg.rpay[1]};
               s_next.pend = 1'b0;
               s_next.st = ST_IDLE;
            end
         end else if (cfg_state) begin
            if (s_reg.rcmd == CMD_CFG_A || s_reg.rcmd == CMD_CFG_B ||
                s_reg.rcmd == CMD_PDEF) begin // see R1
               s_next.tcmd = s_reg.rcmd | RSP_FLAG; // see R2
               s_next.tlen = 8'h00;
               s_next.st = ST_TX;
               if (s_reg.rcmd == CMD_PDEF) s_next.mask = s_reg.rmask; // see R3
            end
         end else if (s_reg.rcmd == CMD_IO) begin
            s_next.in_buf = s_reg.rpay; // see R14
            s_next.tpay = s_reg.out_buf; // see R13
            s_next.tcmd = CMD_IO | RSP_FLAG;
            s_next.tlen = 8'(IO_BYTES);
            s_next.st = ST_TX;
         end
      end

      // master output always lands in the buffer, newest wins
      if (out_wr) s_next.out_buf = out_wr_data; // see R15

      // remote parameter read: drop any partial host frame
      if (prm_req && serial_mode && !cfg_state && s_reg.stat.online && !s_reg.pend) begin
         s_next.pend = 1'b1;
         s_next.rsp.num = prm_req_num;
         s_next.rcnt = 9'h000; // see R10
      end

      case (s_reg.st)
         ST_IDLE: begin
            if (s_next.pend && s_next.st == ST_IDLE) begin
               s_next.st = ST_ATTN; // see R12
               s_next.attn_n = 1'b0; // see R4
               s_next.tmr = '0;
            end
         end
         ST_ATTN: begin
            if (!host_rdy_n) begin
               s_next.attn_n = 1'b1; // see R20
               s_next.tcmd = CMD_PREQ; // see R6
               s_next.tlen = 8'h01;
               s_next.tpay[0] = s_reg.rsp.num;
               s_next.preq = 1'b1;
               s_next.st = ST_TX;
            end else if (s_reg.tmr == TW'(TMO_CYC - 1)) begin
               s_next.attn_n = 1'b1; // see R20
               s_next.rsp.err = 1'b1; // see R9
               s_next.pend = 1'b0;
               s_next.st = ST_IDLE;
            end else begin
               s_next.tmr = s_reg.tmr + 1'b1;
            end
         end
         ST_TX: begin
            if (q_ready) begin
               s_next.tcks = s_reg.tcks + tbyte;
               s_next.tidx = s_reg.tidx + 8'h01;
               if (s_reg.tidx == s_reg.tlen + 8'h02) begin
                  s_next.st = s_reg.preq ? ST_PRSP : ST_IDLE;
                  s_next.preq = 1'b0;
                  s_next.tmr = '0;
                  s_next.rcnt = 9'h000;
               end
            end
         end
         ST_PRSP: begin
            if (s_next.st == ST_PRSP) begin
               if (s_reg.tmr == TW'(TMO_CYC - 1)) begin
                  s_next.rsp.err = 1'b1; // see R9
                  s_next.pend = 1'b0;
                  s_next.st = ST_IDLE;
               end else begin
                  s_next.tmr = s_reg.tmr + 1'b1;
               end
            end
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase

      // frame sender starts each frame from byte zero
      if (s_reg.st != ST_TX) begin
         s_next.tidx = 8'h00;
         s_next.tcks = 8'h00;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.attn_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : fbs_core

`default_nettype wire

// ### dv/fbs_core_asserts.sv
// concurrent checks on the ports of the host serial engine
// assumes it is bound onto fbs_core and shares its single clock and reset
`default_nettype none

module fbs_core_asserts #(
   parameter int TMO_CYC = 2000,
   parameter int BIT_CYC = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic host_txd,
   input wire logic attn_n,
   input wire logic host_rdy_n,
   input wire logic cfg_state,
   input wire logic serial_mode,
   input wire fbs_pkg::fbs_net_t net,
   input wire fbs_pkg::fbs_stat_t stat,
   input wire logic prm_req,
   input wire fbs_pkg::fbs_prm_rsp_t prm_rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   import fbs_pkg::*;

   // ***********************************************
   // helper counters
   // ***********************************************
   int low_cnt;
   int hi_cnt;

   // count cycles of attention low and of an idle transmit line
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= 0;
         hi_cnt <= 0;
      end else begin
         low_cnt <= attn_n ? 0 : low_cnt + 1;
         hi_cnt <= !host_txd ? 0 : (hi_cnt < 1000 ? hi_cnt + 1 : hi_cnt);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // ***********************************************
   // properties
   // ***********************************************
   attn_on_read_a: assert property (
      prm_req && serial_mode && !cfg_state && stat.online && attn_n |-> ##[1:2] !attn_n)
      else $error("attention not raised after remote read");
   attn_release_a: assert property (
      !attn_n && !host_rdy_n |-> ##[1:2] attn_n)
      else $error("attention held after ready");
   attn_bound_a: assert property (low_cnt <= TMO_CYC + 2)
      else $error("attention held past the timeout");
   tmo_release_a: assert property (
      $rose(attn_n) && $past(host_rdy_n) |-> low_cnt >= TMO_CYC - 2)
      else $error("attention dropped early without ready");
   done_pulse_a: assert property (
      prm_rsp.done |=> !prm_rsp.done && !prm_rsp.err)
      else $error("answer flag longer than one cycle");
   quiet_attn_a: assert property (
      !attn_n && hi_cnt >= 10 * BIT_CYC |-> host_txd)
      else $error("host reply sent during attention");
   listen_mode_a: assert property (
      net.auto_baud && !net.can_traffic |=> stat.listening && !stat.online)
      else $error("listening state not shown");
   addr_fault_a: assert property (
      net.addr_conflict |=> stat.net_fault && !stat.online)
      else $error("address conflict not flagged");
   bus_off_a: assert property (
      net.baud_mismatch |=> stat.bus_off && !stat.online)
      else $error("bus off not entered");

endmodule : fbs_core_asserts

bind fbs_core fbs_core_asserts #(.TMO_CYC(TMO_CYC), .BIT_CYC(BIT_CYC)) fbs_core_asserts_inst (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .host_txd(host_txd),
   .attn_n(attn_n),
   .host_rdy_n(host_rdy_n),
   .cfg_state(cfg_state),
   .serial_mode(serial_mode),
   .net(net),
   .stat(stat),
   .prm_req(prm_req),
   .prm_rsp(prm_rsp)
);

`default_nettype wire

// ### dv/fbs_host.sv
// host processor model: 8n1 uart, ready line, frame tasks
// assumes callers act at the falling clock edge
`default_nettype none

module fbs_host #(
   parameter int BIT_CYC = 8
) (
   input wire logic clk,
   input wire logic host_txd,
   input wire logic attn_n,
   output logic host_rxd,
   output logic host_rdy_n
);
   timeunit 1ns;
   timeprecision 1ns;

   // ***********************************************
   // receiver and senders
   // ***********************************************
   logic [7:0] rxq[$];
   logic [7:0] sh;
   int cnt = 0;
   int bitn = 0;

   // idle line high, ready released
   initial begin
      host_rxd = 1'b1;
      host_rdy_n = 1'b1;
   end

   // sample device bytes mid bit, no parity bit expected
   always @(negedge clk) begin
      if (cnt > 0) begin
         cnt--;
         if (cnt == 0 && bitn < 8) begin
            sh = {host_txd, sh[7:1]};
            bitn++;
            cnt = BIT_CYC;
         end else if (cnt == 0) begin
            rxq.push_back(sh);
         end
      end else if (host_txd === 1'b0) begin
         cnt = BIT_CYC + BIT_CYC / 2;
         bitn = 0;
      end
   end

   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         host_rxd = f[i];
         repeat (BIT_CYC) @(negedge clk);
      end
   endtask : send_byte

   // frame with trailing sum of all bytes
   task automatic send_frame(input logic [7:0] f[$]);
      logic [7:0] s;
      s = 8'h00;
      foreach (f[i]) begin
         send_byte(f[i]);
         s += f[i];
      end
      send_byte(s);
   endtask : send_frame

   // confirm ready only after attention is seen
   task automatic ack(input int dly, output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 4000 && !ok; i++) begin
         @(negedge clk);
         ok = (attn_n === 1'b0);
      end
      repeat (dly) @(negedge clk);
      host_rdy_n = !ok;
   endtask : ack

endmodule : fbs_host

`default_nettype wire

// ### dv/test_fieldbus_slave_host_serial_protocol.sv
// self-checking bench for the host serial engine with a host model
// assumes package, design, host model and checker compiled first
`default_nettype none

module test_fieldbus_slave_host_serial_protocol;
   timeunit 1ns;
   timeprecision 1ns;
   import fbs_pkg::*;

   localparam int TMO = 2000;
   localparam int BC = 8;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic host_rxd, host_txd, attn_n, host_rdy_n, cfg_state, serial_mode, prm_req, out_wr;
   logic [7:0] prm_req_num, prm_rw_mask;
   logic [31:0] out_wr_data, in_data;
   fbs_net_t net;
   fbs_stat_t stat;
   fbs_prm_rsp_t prm_rsp;
   int bad_count = 0;
   int check_count = 0;

   // 10 MHz clock
   always #50 core_clk = ~core_clk;

   fbs_core #(.TMO_CYC(TMO), .BIT_CYC(BC)) fbs_core_inst (
      .core_clk(core_clk), .rst_n(rst_n), .host_rxd(host_rxd), .host_txd(host_txd),
      .attn_n(attn_n), .host_rdy_n(host_rdy_n), .cfg_state(cfg_state),
      .serial_mode(serial_mode), .net(net), .stat(stat), .prm_req(prm_req),
      .prm_req_num(prm_req_num), .prm_rsp(prm_rsp), .out_wr(out_wr),
      .out_wr_data(out_wr_data), .in_data(in_data), .prm_rw_mask(prm_rw_mask));

   fbs_host #(.BIT_CYC(BC)) fbs_host_inst (
      .clk(core_clk), .host_txd(host_txd), .attn_n(attn_n), .host_rxd(host_rxd),
      .host_rdy_n(host_rdy_n));

   // ***********************************************
   // shared tasks
   // ***********************************************
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic hang(input string what);
      bad_count++;
      $display("unexpected %s expected event seen timeout", what);
      final_report();
   endtask : hang

   task automatic expect_frame(input logic [7:0] f[$]);
      logic [7:0] s;
      s = 8'h00;
      foreach (f[i]) s += f[i];
      f.push_back(s);
      foreach (f[i]) begin
         for (int n = 0; n < 40 * BC && fbs_host_inst.rxq.size() == 0; n++) @(negedge core_clk);
         if (fbs_host_inst.rxq.size() == 0) hang("reply byte");
         chk("reply byte", f[i], fbs_host_inst.rxq.pop_front());
      end
   endtask : expect_frame

   task automatic quiet(input int n);
      repeat (n) @(negedge core_clk);
      chk("reply bytes", 0, fbs_host_inst.rxq.size());
   endtask : quiet

   task automatic wait_attn(input logic v, input int lim);
      for (int n = 0; n < lim && attn_n !== v; n++) @(negedge core_clk);
      if (attn_n !== v) hang("attention level");
   endtask : wait_attn

   task automatic wait_rsp(input logic err, input int lo, input int lim);
      int n;
      for (n = 0; n < lim && prm_rsp.done !== 1'b1 && prm_rsp.err !== 1'b1; n++) begin
         @(negedge core_clk);
      end
      if (n == lim) hang("parameter answer");
      chk("answer error", err, prm_rsp.err);
      chk("answer delay", 1, n >= lo);
   endtask : wait_rsp

   task automatic ask(input logic [7:0] num);
      prm_req_num = num;
      prm_req = 1'b1;
      @(negedge core_clk);
      prm_req = 1'b0;
   endtask : ask

   task automatic finish_read(input logic [7:0] num, input logic [15:0] d);
      bit ok;
      fbs_host_inst.ack(3, ok);
      if (!ok) hang("attention");
      wait_attn(1'b1, 4);
      expect_frame('{8'h0e, 8'h01, num});
      fbs_host_inst.host_rdy_n = 1'b1;
      fork
         fbs_host_inst.send_frame('{8'h8e, 8'h03, num, d[7:0], d[15:8]});
         wait_rsp(1'b0, 0, 1000);
      join
      chk("answer number", num, prm_rsp.num);
      chk("answer data", d, prm_rsp.data);
   endtask : finish_read

   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic t_cfg;
      fbs_host_inst.send_frame('{8'h10, 8'h00});
      quiet(30 * BC);
      for (int i = 1; i < 3; i++) begin
         fbs_host_inst.send_frame('{8'(i), 8'h00});
         expect_frame('{8'(i) | 8'h80, 8'h00});
      end
      fbs_host_inst.send_frame('{8'h20, 8'h07, 8'h03, 8'h02, 8'h01, 8'h08, 8'h01, 8'h0b,
                                 8'h00});
      expect_frame('{8'ha0, 8'h00});
      chk("rw mask", 8'h03, prm_rw_mask);
   endtask : t_cfg

   task automatic t_io;
      out_wr_data = 32'h44332211;
      out_wr = 1'b1;
      @(negedge core_clk);
      out_wr_data = 32'h88776655;
      @(negedge core_clk);
      out_wr = 1'b0;
      fbs_host_inst.send_frame('{8'h10, 8'h04, 8'ha1, 8'hb2, 8'hc3, 8'hd4});
      expect_frame('{8'h90, 8'h04, 8'h55, 8'h66, 8'h77, 8'h88});
      chk("input data", 32'hd4c3b2a1, in_data);
   endtask : t_io

   task automatic t_tmo;
      ask(8'h05);
      wait_attn(1'b0, 4);
      wait_rsp(1'b1, TMO - 4, TMO + 50);
      wait_attn(1'b1, 4);
   endtask : t_tmo

   task automatic t_discard;
      fbs_host_inst.send_byte(8'h10);
      fbs_host_inst.send_byte(8'h04);
      ask(8'h07);
      wait_attn(1'b0, 4);
      fbs_host_inst.send_frame('{8'h10, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04});
      chk("attention held", 0, attn_n);
      quiet(2);
      finish_read(8'h07, 16'hbeef);
   endtask : t_discard

   task automatic t_net;
      net = 5'b10100;
      repeat (2) @(negedge core_clk);
      chk("status listening", 4'b1000, stat);
      fbs_host_inst.send_frame('{8'h10, 8'h00});
      quiet(30 * BC);
      net = 5'b00110;
      repeat (2) @(negedge core_clk);
      chk("network fault", 1, stat.net_fault);
      chk("online", 0, stat.online);
      net = 5'b00101;
      repeat (2) @(negedge core_clk);
      chk("bus off", 1, stat.bus_off);
      chk("online", 0, stat.online);
   endtask : t_net

   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      cfg_state = 1'b1;
      serial_mode = 1'b1;
      prm_req = 1'b0;
      prm_req_num = 8'h00;
      out_wr = 1'b0;
      out_wr_data = 32'h0;
      net = 5'b00100;
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("attention idle", 1, attn_n);
      chk("rw mask reset", 8'h00, prm_rw_mask);
      t_cfg();
      cfg_state = 1'b0;
      t_io();
      ask(8'h03);
      finish_read(8'h03, 16'h0201);
      t_tmo();
      t_discard();
      t_net();
      final_report();
   end

endmodule : test_fieldbus_slave_host_serial_protocol

`default_nettype wire
